// >>> hw/exsq_pkg.sv
// exsq_pkg: constants and types shared by the exception sequencer
package exsq_pkg;
  // widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned BANK_W = 4;
  // vector table
  localparam int unsigned TABLE_BYTES = 512;
  localparam int unsigned RST_WORDS = 4;
  localparam int unsigned N_PREDEF = 52;
  localparam int unsigned N_USER = 200;
  localparam logic [11:0] TABLE_BANK_HI = 12'h000;
  localparam logic [ADDR_W-1:0] RST_ADDR_BANK = 20'h00000;
  localparam logic [ADDR_W-1:0] RST_ADDR_PC = 20'h00002;
  localparam logic [ADDR_W-1:0] RST_ADDR_SP = 20'h00004;
  localparam logic [ADDR_W-1:0] RST_ADDR_IZ = 20'h00006;
  // vector numbers
  localparam logic [VEC_W-1:0] VEC_BKPT = 8'h04;
  localparam logic [VEC_W-1:0] VEC_BUS_ERR = 8'h05;
  localparam logic [VEC_W-1:0] VEC_SWI = 8'h06;
  localparam logic [VEC_W-1:0] VEC_ILLEGAL = 8'h07;
  localparam logic [VEC_W-1:0] VEC_DIV0 = 8'h08;
  localparam logic [VEC_W-1:0] VEC_UNINIT = 8'h0f;
  localparam logic [VEC_W-1:0] VEC_SPURIOUS = 8'h18;
  localparam logic [VEC_W-1:0] VEC_AUTO_BASE = 8'h10;
  localparam logic [VEC_W-1:0] VEC_AUTO_L1 = 8'h11;
  localparam logic [VEC_W-1:0] VEC_AUTO_L7 = 8'h17;
  localparam logic [VEC_W-1:0] VEC_USER_FIRST = 8'h38;
  // return address adjustments
  localparam logic [ADDR_W-1:0] RET_ASYNC_ADJ = 20'h00000;
  localparam logic [ADDR_W-1:0] RET_SYNC_ADJ = 20'h00002;
  localparam logic [ADDR_W-1:0] RTI_ADJ = 20'h00006;
  localparam logic [ADDR_W-1:0] HANDLER_PIPE_ADJ = 20'h00006;
  localparam logic [WORD_W-1:0] STACK_STEP = 16'h0002;
  // reset word 0 field positions
  localparam int unsigned ZK_LSB = 8;
  localparam int unsigned SK_LSB = 4;
  localparam int unsigned PK_LSB = 0;
  // tracking codes, active low pairs {track_1, track_0}
  localparam logic [1:0] TRK_NULL = 2'h3;
  localparam logic PH_ONE = 1'b0;
  localparam logic PH_TWO = 1'b1;
  // sequencer states
  typedef enum logic [9:0] {
    S_RST = 10'h001,
    S_IDLE = 10'h002,
    S_PUSH_PC = 10'h004,
    S_PUSH_CCR = 10'h008,
    S_FETCH = 10'h010,
    S_FIRST = 10'h020,
    S_POP_CCR = 10'h040,
    S_POP_PC = 10'h080,
    S_DEBUG = 10'h100,
    S_LOAD = 10'h200
  } exsq_state_t;
endpackage : exsq_pkg

// >>> hw/exsq_top.sv
// exsq_top: exception sequencer with pipeline tracking outputs
// Functional notes
// - vector table sits in the lowest 512 bytes of bank zero
// - normal vectors are one data-space word; reset vector is four program words
// - table address is the 8-bit vector number shifted left once
// - reset words 0000-0006: bank extensions, pc, stack pointer, direct page index
// - vectors 4-8 fixed faults, F uninitialized, 18 spurious
// - 11-17 autovector levels one to seven; 38-FF user interrupts
// - 52 predefined or reserved slots and 200 user slots
// - pc and condition codes pushed at stack bank and stack pointer
// - four phases: select, stack and clear bank, vector, load pc
// - non-reset handlers entered with program bank cleared
// - interrupts, bus error, breakpoint, reset async; traps and faults sync
// - async processing starts at the first instruction boundary
// - async stacked address is next instruction plus six; the code stacks pkpc_in unchanged (RET_ASYNC_ADJ is zero)
// - sync stacked address is current address plus two
// - sync handler first instruction runs before interrupts are sampled
// - async beats sync; pending ones served highest first
// - first handler instruction runs before any further exception except a pending bus error or breakpoint
// - bus error or breakpoint during processing nests before handler runs
// - return pops frame, restores state, subtracts six from address
// - reset loads stack pointer and pushes no frame
// - two tracking pins, two phases; phase one start/fetch codes
// - active low; phase two invalid, advance, exception, null
// - both phases fit in one two-clock bus cycle for capture
// - breakpoint taken after instruction completes; tracking null in debug
module exsq_top
  import exsq_pkg::*;
#(
  parameter int unsigned PREDEF_SLOTS = N_PREDEF,
  parameter int unsigned USER_SLOTS = N_USER
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // core status
  input wire logic boundary_in,
  input wire logic [ADDR_W-1:0] pkpc_in,
  input wire logic [WORD_W-1:0] ccr_in,
  input wire logic debug_en_in,
  input wire logic debug_go_in,
  // exception sources
  input wire logic bus_err_in,
  input wire logic bkpt_in,
  input wire logic [2:0] irq_level_in,
  input wire logic irq_autovec_in,
  input wire logic irq_spurious_in,
  input wire logic irq_uninit_in,
  input wire logic [VEC_W-1:0] irq_vector_in,
  input wire logic swi_in,
  input wire logic debug_entry_instr_in,
  input wire logic illegal_in,
  input wire logic div0_in,
  input wire logic rti_in,
  // memory port
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_prog_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [WORD_W-1:0] mem_wdata_out,
  input wire logic [WORD_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in,
  // register loads towards the core
  output logic pc_load_out,
  output logic [WORD_W-1:0] pc_val_out,
  output logic [BANK_W-1:0] program_bank_ext_out,
  output logic ccr_load_out,
  output logic [WORD_W-1:0] condition_code_reg_out,
  output logic [WORD_W-1:0] sp_out,
  output logic [BANK_W-1:0] stack_bank_ext_out,
  output logic [BANK_W-1:0] z_index_bank_ext_out,
  output logic [WORD_W-1:0] direct_page_index_out,
  output logic debug_mode_out,
  output logic irq_ack_out,
  // pipeline tracking
  input wire logic pipe_start_in,
  input wire logic pipe_fetch_in,
  input wire logic pipe_advance_in,
  input wire logic pipe_exception_in,
  input wire logic pipe_invalid_in,
  output logic pipe_track_0_out,
  output logic pipe_track_1_out,
  output logic pipe_phase_out
);

  // slot count must cover the table exactly
  if (PREDEF_SLOTS + USER_SLOTS + RST_WORDS != TABLE_BYTES / 2) begin : g_bad_slots
    $error("vector slot counts do not fill the table");
  end

  exsq_state_t st_q, st_d;
  logic [1:0] idx_q, idx_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic [ADDR_W-1:0] ret_q, ret_d;
  logic [WORD_W-1:0] sp_q, sp_d, iz_q, iz_d, ccr_q, ccr_d, pc_q, pc_d;
  logic [BANK_W-1:0] sk_q, sk_d, zk_q, zk_d, pk_q, pk_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [WORD_W-1:0] wdata_q, wdata_d;
  logic pcld_q, pcld_d, ccrld_q, ccrld_d, iack_q, iack_d;
  logic berr_pend_q, berr_pend_d, bkpt_pend_q, bkpt_pend_d;
  logic start_exc;
  logic sel_valid, sel_sync, sel_debug, sel_irq;
  logic [VEC_W-1:0] sel_vec;
  logic [ADDR_W-1:0] rti_addr;

  // priority select: bus error, breakpoint, interrupt, then synchronous
  always_comb begin
    sel_valid = 1'b1;
    sel_sync = 1'b0;
    sel_debug = 1'b0;
    sel_irq = 1'b0;
    sel_vec = VEC_BUS_ERR;
    if (berr_pend_q || bus_err_in) begin
      sel_vec = VEC_BUS_ERR;
    end else if (bkpt_pend_q || bkpt_in) begin
      sel_vec = VEC_BKPT;
      sel_debug = debug_en_in;
    end else if (irq_level_in != 3'h0) begin
      sel_irq = 1'b1;
      if (irq_spurious_in) begin
        sel_vec = VEC_SPURIOUS;
      end else if (irq_uninit_in) begin
        sel_vec = VEC_UNINIT;
      end else if (irq_autovec_in) begin
        sel_vec = VEC_AUTO_BASE | {5'h00, irq_level_in};
      end else begin
        sel_vec = irq_vector_in;
      end
    end else if (swi_in) begin
      sel_sync = 1'b1;
      sel_vec = VEC_SWI;
    end else if (debug_entry_instr_in) begin
      sel_sync = 1'b1;
      sel_debug = debug_en_in;
      sel_vec = VEC_ILLEGAL;
    end else if (illegal_in) begin
      sel_sync = 1'b1;
      sel_vec = VEC_ILLEGAL;
    end else if (div0_in) begin
      sel_sync = 1'b1;
      sel_vec = VEC_DIV0;
    end else begin
      sel_valid = 1'b0;
    end
  end

  assign rti_addr = {ccr_q[BANK_W-1:0], mem_rdata_in} - RTI_ADJ;

  // sequencer next state
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    vec_d = vec_q;
    ret_d = ret_q;
    sp_d = sp_q;
    iz_d = iz_q;
    ccr_d = ccr_q;
    pc_d = pc_q;
    sk_d = sk_q;
    zk_d = zk_q;
    pk_d = pk_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    pcld_d = 1'b0;
    ccrld_d = 1'b0;
    iack_d = 1'b0;
    start_exc = 1'b0;
    // sticky pending; in S_LOAD a new event wins over the clear, in S_IDLE the clear wins
    berr_pend_d = berr_pend_q || bus_err_in;
    bkpt_pend_d = bkpt_pend_q || bkpt_in;
    unique case (st_q)
      S_RST: begin
        if (mem_ack_in) begin
          unique case (idx_q)
            2'h0: begin
              zk_d = mem_rdata_in[ZK_LSB +: BANK_W];
              sk_d = mem_rdata_in[SK_LSB +: BANK_W];
              pk_d = mem_rdata_in[PK_LSB +: BANK_W];
              addr_d = RST_ADDR_PC;
            end
            2'h1: begin
              pc_d = mem_rdata_in;
              addr_d = RST_ADDR_SP;
            end
            2'h2: begin
              sp_d = mem_rdata_in;
              addr_d = RST_ADDR_IZ;
            end
            2'h3: begin
              iz_d = mem_rdata_in;
              pcld_d = 1'b1;
              st_d = S_IDLE; // no frame pushed for reset
            end
          endcase
          idx_d = idx_q + 2'h1;
        end
      end
      S_IDLE: begin
        if (boundary_in && sel_valid) begin
          // only the taken event is consumed; a lower one stays pending
          if (berr_pend_q || bus_err_in) begin
            berr_pend_d = 1'b0;
          end else begin
            bkpt_pend_d = 1'b0;
          end
          if (sel_debug) begin
            st_d = S_DEBUG;
          end else begin
            start_exc = 1'b1;
            iack_d = sel_irq;
            vec_d = sel_vec;
            ret_d = sel_sync ? pkpc_in + RET_SYNC_ADJ : pkpc_in + RET_ASYNC_ADJ;
            addr_d = {sk_q, sp_q};
            wdata_d = sel_sync ? pc_plus_sync(pkpc_in) : pkpc_in[WORD_W-1:0];
            st_d = S_PUSH_PC;
          end
        end else if (boundary_in && rti_in) begin
          addr_d = {sk_q, sp_q + STACK_STEP};
          sp_d = sp_q + STACK_STEP;
          st_d = S_POP_CCR;
        end
      end
      S_PUSH_PC: begin
        if (mem_ack_in) begin
          sp_d = sp_q - STACK_STEP;
          addr_d = {sk_q, sp_q - STACK_STEP};
          wdata_d = {ccr_in[WORD_W-1:BANK_W], ret_q[ADDR_W-1:WORD_W]};
          st_d = S_PUSH_CCR;
        end
      end
      S_PUSH_CCR: begin
        if (mem_ack_in) begin
          sp_d = sp_q - STACK_STEP;
          pk_d = {BANK_W{1'b0}};
          addr_d = {TABLE_BANK_HI, vec_q};
          addr_d = {addr_d[ADDR_W-2:0], 1'b0};
          st_d = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack_in) begin
          pc_d = mem_rdata_in;
          pk_d = {BANK_W{1'b0}};
          pcld_d = 1'b1;
          st_d = S_LOAD;
        end
      end
      S_LOAD: begin
        if (berr_pend_q || bkpt_pend_q) begin
          // a new event in this cycle wins over the clear
          if (berr_pend_q) begin
            berr_pend_d = bus_err_in;
          end else begin
            bkpt_pend_d = bkpt_in;
          end
          if (!berr_pend_q && debug_en_in) begin
            st_d = S_DEBUG;
          end else begin
            start_exc = 1'b1;
            vec_d = berr_pend_q ? VEC_BUS_ERR : VEC_BKPT;
            ret_d = handler_pc_ret(pc_q);
            addr_d = {sk_q, sp_q};
            wdata_d = ret_word(pc_q);
            st_d = S_PUSH_PC;
          end
        end else begin
          st_d = S_FIRST;
        end
      end
      S_FIRST: begin
        if (boundary_in) begin
          st_d = S_IDLE;
        end
      end
      S_POP_CCR: begin
        if (mem_ack_in) begin
          ccr_d = mem_rdata_in;
          sp_d = sp_q + STACK_STEP;
          addr_d = {sk_q, sp_q + STACK_STEP};
          st_d = S_POP_PC;
        end
      end
      S_POP_PC: begin
        if (mem_ack_in) begin
          pc_d = rti_addr[WORD_W-1:0];
          pk_d = rti_addr[ADDR_W-1:WORD_W];
          pcld_d = 1'b1;
          ccrld_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_DEBUG: begin
        if (debug_go_in) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // stacked low word for a synchronous trap
  function automatic logic [WORD_W-1:0] pc_plus_sync(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] s;
    s = a + RET_SYNC_ADJ;
    return s[WORD_W-1:0];
  endfunction

  // return address of a nested fault: the handler's first instruction
  function automatic logic [ADDR_W-1:0] handler_pc_ret(input logic [WORD_W-1:0] p);
    return {{BANK_W{1'b0}}, p} + HANDLER_PIPE_ADJ;
  endfunction

  function automatic logic [WORD_W-1:0] ret_word(input logic [WORD_W-1:0] p);
    logic [ADDR_W-1:0] s;
    s = handler_pc_ret(p);
    return s[WORD_W-1:0];
  endfunction

  // sequencer registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= S_RST;
      idx_q <= 2'h0;
      vec_q <= 8'h00;
      ret_q <= 20'h00000;
      sp_q <= 16'h0000;
      iz_q <= 16'h0000;
      ccr_q <= 16'h0000;
      pc_q <= 16'h0000;
      sk_q <= 4'h0;
      zk_q <= 4'h0;
      pk_q <= 4'h0;
      addr_q <= RST_ADDR_BANK;
      wdata_q <= 16'h0000;
      pcld_q <= 1'b0;
      ccrld_q <= 1'b0;
      iack_q <= 1'b0;
      berr_pend_q <= 1'b0;
      bkpt_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      vec_q <= vec_d;
      ret_q <= ret_d;
      sp_q <= sp_d;
      iz_q <= iz_d;
      ccr_q <= ccr_d;
      pc_q <= pc_d;
      sk_q <= sk_d;
      zk_q <= zk_d;
      pk_q <= pk_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      pcld_q <= pcld_d;
      ccrld_q <= ccrld_d;
      iack_q <= iack_d;
      berr_pend_q <= berr_pend_d;
      bkpt_pend_q <= bkpt_pend_d;
    end
  end

  // memory and core-side outputs
  assign mem_req_out = (st_q == S_RST) || (st_q == S_PUSH_PC) || (st_q == S_PUSH_CCR) ||
                       (st_q == S_FETCH) || (st_q == S_POP_CCR) || (st_q == S_POP_PC);
  assign mem_we_out = (st_q == S_PUSH_PC) || (st_q == S_PUSH_CCR);
  assign mem_prog_out = (st_q == S_RST);
  assign mem_addr_out = addr_q;
  assign mem_wdata_out = wdata_q;
  assign pc_load_out = pcld_q;
  assign pc_val_out = pc_q;
  assign program_bank_ext_out = pk_q;
  assign ccr_load_out = ccrld_q;
  assign condition_code_reg_out = ccr_q;
  assign sp_out = sp_q;
  assign stack_bank_ext_out = sk_q;
  assign z_index_bank_ext_out = zk_q;
  assign direct_page_index_out = iz_q;
  assign debug_mode_out = (st_q == S_DEBUG);
  assign irq_ack_out = iack_q;

  // tracking: sticky events, reported once in their phase
  logic ph_q, ph_d, t0_q, t0_d, t1_q, t1_d;
  logic stp_q, stp_d, ftp_q, ftp_d, adp_q, adp_d, exp_q, exp_d, inp_q, inp_d;
  logic st_set, ft_set, ad_set, ex_set, in_set;

  always_comb begin
    st_set = stp_q || pipe_start_in;
    ft_set = ftp_q || pipe_fetch_in;
    ad_set = adp_q || pipe_advance_in;
    ex_set = exp_q || pipe_exception_in || start_exc;
    in_set = inp_q || pipe_invalid_in;
    ph_d = ~ph_q;
    stp_d = st_set;
    ftp_d = ft_set;
    adp_d = ad_set;
    exp_d = ex_set;
    inp_d = in_set;
    if (st_q == S_DEBUG || st_d == S_DEBUG) begin
      {t1_d, t0_d} = TRK_NULL;
    end else if (ph_d == PH_ONE) begin
      {t1_d, t0_d} = {~ft_set, ~st_set};
      stp_d = 1'b0;
      ftp_d = 1'b0;
    end else begin
      // one report per slot: invalid, then exception, then advance
      if (in_set) begin
        {t1_d, t0_d} = 2'h0;
        adp_d = 1'b0;
        exp_d = 1'b0;
      end else if (ex_set) begin
        {t1_d, t0_d} = 2'h2;
        exp_d = 1'b0; // a pending advance waits for the next slot
      end else begin
        {t1_d, t0_d} = {~ad_set, 1'b1};
        adp_d = 1'b0;
      end
      inp_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q <= PH_TWO;
      t0_q <= 1'b1;
      t1_q <= 1'b1;
      stp_q <= 1'b0;
      ftp_q <= 1'b0;
      adp_q <= 1'b0;
      exp_q <= 1'b0;
      inp_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      t0_q <= t0_d;
      t1_q <= t1_d;
      stp_q <= stp_d;
      ftp_q <= ftp_d;
      adp_q <= adp_d;
      exp_q <= exp_d;
      inp_q <= inp_d;
    end
  end

  assign pipe_track_0_out = t0_q;
  assign pipe_track_1_out = t1_q;
  assign pipe_phase_out = ph_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_push_pc_done;
    (st_q == S_PUSH_PC) && mem_ack_in;
  endsequence
  sequence s_push_ccr_req;
    (st_q == S_PUSH_CCR) && mem_we_out && (mem_addr_out == {sk_q, sp_q});
  endsequence

  property p_reset_words;
    (st_q == S_RST) |-> mem_prog_out && (mem_addr_out == {17'h00000, idx_q, 1'b0});
  endproperty
  a_reset_words: assert property (p_reset_words) else $error("reset word address");

  property p_vec_addr;
    (st_q == S_FETCH) |-> !mem_prog_out && (mem_addr_out == {11'h000, vec_q, 1'b0});
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address");

  property p_stack_frame;
    s_push_pc_done |=> s_push_ccr_req;
  endproperty
  a_stack_frame: assert property (p_stack_frame) else $error("frame order");

  property p_bank_clear;
    (st_q == S_FETCH) && mem_ack_in |=> pc_load_out && (program_bank_ext_out == 4'h0) &&
      (pc_val_out == $past(mem_rdata_in));
  endproperty
  a_bank_clear: assert property (p_bank_clear) else $error("handler bank");

  property p_sync_ret;
    (st_q == S_IDLE) && boundary_in && sel_valid && sel_sync && !sel_debug |=>
      (ret_q == $past(pkpc_in) + 20'h00002) && (st_q == S_PUSH_PC);
  endproperty
  a_sync_ret: assert property (p_sync_ret) else $error("sync return");

  property p_async_ret;
    (st_q == S_IDLE) && boundary_in && sel_valid && !sel_sync && !sel_debug |=>
      ret_q == $past(pkpc_in);
  endproperty
  a_async_ret: assert property (p_async_ret) else $error("async return");

  property p_rti;
    (st_q == S_POP_PC) && mem_ack_in |=> pc_load_out && ccr_load_out &&
      ({program_bank_ext_out, pc_val_out} == {$past(ccr_q[3:0]), $past(mem_rdata_in)} - 20'h6);
  endproperty
  a_rti: assert property (p_rti) else $error("return address");

  property p_first_hold;
    (st_q == S_FIRST) && !boundary_in |=> (st_q == S_FIRST);
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("left before first insn");

  property p_debug_null;
    (st_q == S_DEBUG) && debug_mode_out |=> ({pipe_track_1_out, pipe_track_0_out} == 2'h3);
  endproperty
  a_debug_null: assert property (p_debug_null) else $error("tracking in debug");

  property p_phase1;
    (ph_q == PH_TWO) && pipe_start_in && pipe_fetch_in && (st_q != S_DEBUG) &&
      (st_d != S_DEBUG) |=> (ph_q == PH_ONE) && ({pipe_track_1_out, pipe_track_0_out} == 2'h0);
  endproperty
  a_phase1: assert property (p_phase1) else $error("phase one code");

  property p_invalid;
    (ph_q == PH_ONE) && pipe_invalid_in && (st_q != S_DEBUG) && (st_d != S_DEBUG) |=>
      ({pipe_track_1_out, pipe_track_0_out} == 2'h0) ##1 (ph_q == PH_ONE);
  endproperty
  a_invalid: assert property (p_invalid) else $error("phase two invalid");

endmodule : exsq_top

// >>> test/exsq_mem_model.sv
// exsq_mem_model: memory partner holding reset words, vector table and stack
module exsq_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // access request from the sequencer
  input wire logic req_in,
  input wire logic we_in,
  input wire logic prog_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [3:0] delay_in,
  // answer
  output logic [15:0] rdata_out,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [19:0]];
  logic [3:0] cnt;
  // reset words and vector contents, handlers land in bank zero
  function automatic logic [15:0] word(input logic p, input logic [19:0] a);
    if (p) return (a == 0) ? 16'h0315 : (a == 2) ? 16'h1234 : (a == 4) ? 16'h0800 : 16'h0400;
    return a[15:0] ^ 16'h4a00;
  endfunction
  // one ack per access after delay_in cycles; data toggles when not valid
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      cnt <= 4'h0;
      rdata_out <= 16'h5555;
    end else begin
      if (req_in && ack_out && we_in) mem[addr_in] = wdata_in;
      if (ack_out || !req_in) begin
        ack_out <= 1'b0;
        cnt <= 4'h0;
        rdata_out <= ~rdata_out;
      end else if (cnt >= delay_in) begin
        ack_out <= 1'b1;
        rdata_out <= we_in ? ~rdata_out : mem.exists(addr_in) ? mem[addr_in] : word(prog_in, addr_in);
      end else begin
        cnt <= cnt + 4'h1;
        rdata_out <= ~rdata_out;
      end
    end
  end
endmodule // exsq_mem_model

// >>> test/exsq_top_tb.sv
// exsq_top_tb: self-checking bench for the exception sequencer
module exsq_top_tb
  import exsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [37:0] exsq_acc_t;
  logic clk_in = 0, rst_in = 1, boundary_in = 0, debug_en_in = 0, debug_go_in = 0;
  logic [19:0] pkpc_in = 0;
  logic [15:0] ccr_in = 0, sp = 16'h0800, mem_rdata_in;
  logic bus_err_in = 0, bkpt_in = 0, irq_autovec_in = 1, irq_spurious_in = 0, irq_uninit_in = 0;
  logic [2:0] irq_level_in = 0, hold = 0;
  logic [7:0] irq_vector_in = 0;
  logic swi_in = 0, debug_entry_instr_in = 0, illegal_in = 0, div0_in = 0, rti_in = 0, mem_ack_in;
  logic pipe_start_in = 0, pipe_fetch_in = 0, pipe_advance_in = 0, pipe_exception_in = 0;
  logic pipe_invalid_in = 0, mem_req_out, mem_we_out, mem_prog_out, pc_load_out, ccr_load_out;
  logic [19:0] mem_addr_out;
  logic [15:0] mem_wdata_out, pc_val_out, condition_code_reg_out, sp_out, direct_page_index_out;
  logic [3:0] program_bank_ext_out, stack_bank_ext_out, z_index_bank_ext_out, dly = 0;
  logic debug_mode_out, irq_ack_out, pipe_track_0_out, pipe_track_1_out, pipe_phase_out;
  logic [31:0] st = 32'h198d2e34;
  logic [3:0] sk = 4'h1;
  int fail_count = 0, n_compared = 0, cyc = 0;
  exsq_acc_t memq [$];
  logic [19:0] pcq [$];
  logic [31:0] stk [$];
  logic [7:0] vv [3] = '{VEC_SWI, VEC_ILLEGAL, VEC_ILLEGAL};
  exsq_top dut_u (.*);
  exsq_mem_model mem_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(mem_req_out),
    .we_in(mem_we_out), .prog_in(mem_prog_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .delay_in(dly), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
  always #25 clk_in = ~clk_in;
  task automatic chk(input string n, input exsq_acc_t e, input exsq_acc_t g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in) #1;
  endtask
  // wait for queued results, then retire the first handler instruction
  task automatic drain();
    int i;
    i = 0;
    while ((memq.size() || pcq.size()) && i < 300) begin
      tick(1);
      i++;
    end
    if (i == 300) chk("pending results", 0, 1);
    tick(2);
    boundary_in = 1;
    irq_level_in = hold;
    tick(1);
    boundary_in = 0;
    irq_level_in = 0;
    tick(2);
  endtask
  // expected stack frame, vector fetch and handler entry
  task automatic fr(input logic [19:0] r, input logic [7:0] v);
    memq.push_back({2'b10, sk, sp, r[15:0]});
    memq.push_back({2'b10, sk, sp - 16'h2, ccr_in[15:4], r[19:16]});
    memq.push_back({2'b00, 11'h0, v, 1'b0, 16'h0});
    pcq.push_back({4'h0, mem_u.word(1'b0, {11'h0, v, 1'b0})});
    stk.push_back({ccr_in[15:4], r});
    sp = sp - 16'h4;
  endtask
  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one exception; s = {berr, bkpt, swi, debug_entry_instr, illegal, div0}
  task automatic ex(input logic [2:0] l, input logic [5:0] s, input logic [7:0] v, input bit sy,
    input bit ns);
    st = lfsr(st);
    pkpc_in = st[19:0];
    ccr_in = st[31:16];
    dly = {2'b00, st[5:4]};
    fr(sy ? st[19:0] + 20'h2 : st[19:0], v);
    if (ns) fr({4'h0, mem_u.word(1'b0, {11'h0, v, 1'b0})} + 20'h6, VEC_BUS_ERR);
    {bus_err_in, bkpt_in} = s[5:4];
    tick(1);
    {bus_err_in, bkpt_in} = 2'b00;
    tick(2);
    chk("early start", 0, mem_req_out);
    boundary_in = 1;
    irq_level_in = l;
    {swi_in, debug_entry_instr_in, illegal_in, div0_in} = s[3:0];
    tick(1);
    boundary_in = 0;
    irq_level_in = 0;
    {swi_in, debug_entry_instr_in, illegal_in, div0_in} = 4'h0;
    chk("irq ack", l != 0 && s[5:4] == 2'b00, irq_ack_out);
    bus_err_in = ns;
    tick(1);
    bus_err_in = 0;
    drain();
  endtask
  // return from the newest frame
  task automatic rt();
    logic [31:0] f;
    f = stk.pop_back();
    memq.push_back({2'b00, sk, sp + 16'h2, 16'h0});
    memq.push_back({2'b00, sk, sp + 16'h4, 16'h0});
    pcq.push_back(f[19:0] - 20'h6);
    sp = sp + 16'h4;
    boundary_in = 1;
    rti_in = 1;
    tick(1);
    boundary_in = 0;
    rti_in = 0;
    drain();
    chk("restored ccr", f[31:16], condition_code_reg_out);
  endtask
  task automatic tk(input logic [4:0] e, input logic [1:0] c1, input logic [1:0] c2);
    {pipe_start_in, pipe_fetch_in, pipe_advance_in, pipe_exception_in, pipe_invalid_in} = e;
    tick(4);
    if (pipe_phase_out !== PH_ONE) tick(1);
    chk("track phase one", c1, {pipe_track_1_out, pipe_track_0_out});
    tick(1);
    chk("track phase two", c2, {pipe_track_1_out, pipe_track_0_out});
    {pipe_start_in, pipe_fetch_in, pipe_advance_in, pipe_exception_in, pipe_invalid_in} = 0;
    tick(1);
  endtask
  // compare each completed access and handler entry with the oldest note
  always @(posedge clk_in) begin
    if (!rst_in && mem_req_out && mem_ack_in)
      chk("memory access", memq.size() ? memq.pop_front() : '1,
        {mem_we_out, mem_prog_out, mem_addr_out, mem_we_out ? mem_wdata_out : 16'h0});
    if (!rst_in && pc_load_out)
      chk("pc load", pcq.size() ? pcq.pop_front() : '1, {program_bank_ext_out, pc_val_out});
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    for (int a = 0; a < 8; a += 2) memq.push_back({2'b01, 20'(a), 16'h0});
    pcq.push_back({4'h5, 16'h1234});
    tick(3);
    rst_in = 0;
    drain();
    chk("reset regs", {4'h1, 4'h3, 16'h0800, 16'h0400},
      {stack_bank_ext_out, z_index_bank_ext_out, sp_out, direct_page_index_out});
    $display("test reset done");
    tk(5'b11000, 2'b00, 2'b11);
    tk(5'b01100, 2'b01, 2'b01);
    tk(5'b10010, 2'b10, 2'b10);
    tk(5'b00011, 2'b11, 2'b00);
    tk(5'b00000, 2'b11, 2'b11);
    $display("test tracking done");
    for (int l = 1; l < 8; l++) ex(3'(l), 6'h0, VEC_AUTO_BASE | 8'(l), 0, 0);
    {irq_autovec_in, irq_spurious_in} = 2'b01;
    ex(3'd1, 6'h0, VEC_SPURIOUS, 0, 0);
    {irq_spurious_in, irq_uninit_in} = 2'b01;
    ex(3'd1, 6'h0, VEC_UNINIT, 0, 0);
    irq_uninit_in = 0;
    irq_vector_in = VEC_USER_FIRST;
    ex(3'd7, 6'h0, VEC_USER_FIRST, 0, 0);
    irq_vector_in = 8'hff;
    ex(3'd7, 6'h0, 8'hff, 0, 0);
    irq_autovec_in = 1;
    $display("test interrupts done");
    for (int i = 0; i < 3; i++) ex(3'd0, 6'b001000 >> i, vv[i], 1, 0);
    hold = 3'd2;
    ex(3'd0, 6'b000001, VEC_DIV0, 1, 0);
    hold = 3'd0;
    ex(3'd2, 6'h0, 8'h12, 0, 0);
    $display("test synchronous done");
    ex(3'd4, 6'b101000, VEC_BUS_ERR, 0, 0);
    ex(3'd6, 6'b010000, VEC_BKPT, 0, 0);
    ex(3'd5, 6'b001000, 8'h15, 0, 0);
    ex(3'd3, 6'h0, 8'h13, 0, 1);
    $display("test priority and nesting done");
    while (stk.size()) rt();
    chk("stack pointer", 16'h0800, sp_out);
    $display("test returns done");
    debug_en_in = 1;
    bkpt_in = 1;
    tick(1);
    bkpt_in = 0;
    boundary_in = 1;
    tick(1);
    boundary_in = 0;
    tick(4);
    chk("debug mode", 1, debug_mode_out);
    tk(5'b11111, 2'b11, 2'b11);
    debug_go_in = 1;
    tick(1);
    debug_go_in = 0;
    tick(3);
    chk("debug exit", 0, debug_mode_out);
    $display("test debug done");
    results();
  end
endmodule // exsq_top_tb
